// ---- design/chsf_pkg.sv ----
// Package with register map, field layout and carrier types of chsf
package chsf_pkg;
    // Register addresses
    localparam logic [7:0] CHSF_OFS_STATUS  = 8'h00;
    localparam logic [7:0] CHSF_OFS_FAULT   = 8'h01;
    localparam logic [7:0] CHSF_OFS_TS      = 8'h02;
    // Fixed seven-bit target address of the serial port
    localparam logic [6:0] CHSF_TARGET_ADDR = 7'h6A;
    // Value returned for any address outside the map
    localparam logic [7:0] CHSF_UNMAPPED    = 8'hFF;

    // Status register field positions
    localparam int CHSF_STATE_MSB  = 7;
    localparam int CHSF_SHIP_BIT   = 5;
    localparam int CHSF_RSTF_BIT   = 4;
    localparam int CHSF_TIMER_BIT  = 3;
    localparam int CHSF_DPM_BIT    = 2;
    localparam int CHSF_CD_BIT     = 1;
    localparam int CHSF_SWEN_BIT   = 0;
    // Fault register field positions
    localparam int CHSF_OV_BIT     = 7;
    localparam int CHSF_UV_BIT     = 6;
    localparam int CHSF_LOCK_BIT   = 5;
    localparam int CHSF_OCP_BIT    = 4;
    localparam int CHSF_MASK_MSB   = 3;
    // Temperature-sense register field positions
    localparam int CHSF_TSEN_BIT   = 7;
    localparam int CHSF_TSF_MSB    = 6;
    localparam int CHSF_TSLOW_MSB  = 3;

    // Reset values
    localparam logic       CHSF_SHIP_RST  = 1'b0;
    localparam logic       CHSF_SWEN_RST  = 1'b1;
    localparam logic [3:0] CHSF_MASK_RST  = 4'h0;
    localparam logic       CHSF_TSEN_RST  = 1'b1;
    localparam logic [3:0] CHSF_TSLOW_RST = 4'h8;

    // Charge state codes
    localparam logic [1:0] CHSF_CHG_FAULT = 2'h3;

    // Conditions reported by the analogue side
    typedef struct packed {
        logic [1:0] charge_state;
        logic       reset_event;
        logic       timer_event;
        logic       input_dynamic_power_mgmt;
        logic       chip_disable_pin;
        logic       output_switch_enabled;
        logic       input_overvoltage;
        logic       input_undervoltage;
        logic       battery_lockout;
        logic       battery_overcurrent;
        logic [1:0] ts_fault;
    } chsf_cond_t;

    // Software-written controls
    typedef struct packed {
        logic       ship_request;
        logic [3:0] fault_mask;
        logic       ts_enable;
        logic [3:0] ts_mask;
    } chsf_ctrl_t;

    // One register access from the serial engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } chsf_acc_t;
endpackage : chsf_pkg

// ---- design/chsf_i2c_target.sv ----
// Serial two-wire target engine of chsf, turns bus bytes into accesses
`timescale 1ns/1ps
module chsf_i2c_target (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             ce_in,
    // Bus pins
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output logic                  sda_oe_out,
    // Register side
    output chsf_pkg::chsf_acc_t   acc_out,
    input  wire logic [7:0]       rd_data_in
);
    import chsf_pkg::*;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'b000_0001,
        ST_ADDR  = 7'b000_0010,
        ST_PTR   = 7'b000_0100,
        ST_WDATA = 7'b000_1000,
        ST_RDATA = 7'b001_0000,
        ST_MACK  = 7'b010_0000,
        ST_ACK   = 7'b100_0000
    } chsf_st_t;

    logic       scl_meta, scl_s, scl_d;  // Clock line sync and history
    logic       sda_meta, sda_s, sda_d;  // Data line sync and history
    chsf_st_t   state, next_state;       // Protocol state
    chsf_st_t   after, next_after;       // State after the ack bit
    logic [2:0] cnt, next_cnt;           // Bit counter
    logic [7:0] shreg, next_shreg;       // Shift register
    logic [7:0] ptr, next_ptr;           // Register pointer
    logic       got_ack, next_got_ack;   // Host acked last read byte
    logic       next_oe;                 // Next data pin enable
    logic [7:0] byte_in;                 // Byte with current bit added
    logic       rise, fall, start, stop;

    // Edge and bus condition detection on second- and third-stage samples only
    always_comb begin
        rise    = scl_s & ~scl_d;
        fall    = ~scl_s & scl_d;
        start   = scl_s & scl_d & sda_d & ~sda_s;
        stop    = scl_s & scl_d & ~sda_d & sda_s;
        byte_in = {shreg[6:0], sda_s};
    end

    // Next-state logic of the protocol engine
    always_comb begin
        next_state   = state;
        next_after   = after;
        next_cnt     = cnt;
        next_shreg   = shreg;
        next_ptr     = ptr;
        next_got_ack = got_ack;
        next_oe      = sda_oe_out;
        acc_out      = '0;
        acc_out.addr = ptr;
        if (start) begin
            // Start or repeated start restarts address phase
            next_state = ST_ADDR;
            next_cnt   = 3'h0;
            next_oe    = 1'b0;
        end else if (stop) begin
            next_state = ST_IDLE;
            next_oe    = 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (rise) begin
                        next_shreg = byte_in;
                        next_cnt   = 3'(cnt + 3'h1);
                        if (cnt == 3'h7) begin
                            next_state = ST_ACK;
                            next_after = ST_WDATA;
                            if (state == ST_ADDR) begin
                                // Only our own seven-bit address
                                if (byte_in[7:1] != CHSF_TARGET_ADDR)
                                    next_state = ST_IDLE;
                                else if (byte_in[0])
                                    next_after = ST_RDATA;
                                else
                                    next_after = ST_PTR;
                            end else if (state == ST_PTR) begin
                                next_ptr = byte_in;
                            end else begin
                                // Write, then advance the pointer
                                acc_out.wr    = 1'b1;
                                acc_out.wdata = byte_in;
                                next_ptr      = 8'(ptr + 8'h01);
                            end
                        end
                    end
                end
                ST_ACK: begin
                    // Pull low for the whole ninth clock
                    if (fall && !sda_oe_out) begin
                        next_oe = 1'b1;
                    end else if (fall) begin
                        next_oe    = 1'b0;
                        next_state = after;
                        next_cnt   = 3'h0;
                        if (after == ST_RDATA) begin
                            acc_out.rd = 1'b1;
                            next_shreg = rd_data_in;
                            next_ptr   = 8'(ptr + 8'h01);
                            next_oe    = ~rd_data_in[7];
                        end
                    end
                end
                ST_RDATA: begin
                    if (fall && cnt == 3'h7) begin
                        next_oe      = 1'b0;
                        next_state   = ST_MACK;
                        next_got_ack = 1'b0;
                    end else if (fall) begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_oe    = ~shreg[6];
                        next_cnt   = 3'(cnt + 3'h1);
                    end
                end
                ST_MACK: begin
                    // Not-ack ends the read burst
                    if (rise && sda_s) begin
                        next_state = ST_IDLE;
                    end else if (rise) begin
                        next_got_ack = 1'b1;
                    end else if (fall && got_ack) begin
                        acc_out.rd = 1'b1;
                        next_shreg = rd_data_in;
                        next_ptr   = 8'(ptr + 8'h01);
                        next_oe    = ~rd_data_in[7];
                        next_state = ST_RDATA;
                        next_cnt   = 3'h0;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // State registers, frozen while the enable is low
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            {scl_meta, scl_s, scl_d} <= 3'h7;
            {sda_meta, sda_s, sda_d} <= 3'h7;
            state      <= ST_IDLE;
            after      <= ST_IDLE;
            cnt        <= 3'h0;
            shreg      <= 8'h00;
            ptr        <= 8'h00;
            got_ack    <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (ce_in) begin
            scl_meta   <= scl_in;
            scl_s      <= scl_meta;
            scl_d      <= scl_s;
            sda_meta   <= sda_in;
            sda_s      <= sda_meta;
            sda_d      <= sda_s;
            state      <= next_state;
            after      <= next_after;
            cnt        <= next_cnt;
            shreg      <= next_shreg;
            ptr        <= next_ptr;
            got_ack    <= next_got_ack;
            sda_oe_out <= next_oe;
        end
    end
endmodule : chsf_i2c_target

// ---- design/chsf_regs.sv ----
// Status, ship-mode, fault and mask registers of chsf (top level)
// Behaviour
// - Charge state code in status bits 7..6
// - Status bit 5 writes ship-mode request
// - Reset-fault flag sets, clears on status read
// - Timer fault holds until chip-disable toggles
// - Status bit 2 shows live power limiting
// - Overvoltage flag persists while condition lasts
// - Undervoltage flag reports once, clears on read
// - Battery lockout flag persists while present
// - Battery overcurrent flag clears on read
// - Low fault bits mask the four faults (here only stored, read back and driven out as fault_mask; the flags still set)
// - Status at 0x00, ship 0, switch 1
// - Fault register at 0x01, masks reset 0
// - Temp-sense register at 0x02, resets 1xx0_1000
// - Unmapped reads return all ones
// - Target answers seven-bit address 0x6A
`timescale 1ns/1ps
module chsf_regs (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire logic              ce_in,
    // Serial bus pins
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_out,
    // Conditions from the charger
    input  chsf_pkg::chsf_cond_t   cond_in,
    // Controls to the charger
    output chsf_pkg::chsf_ctrl_t   ctrl_out
);
    import chsf_pkg::*;

    chsf_cond_t cond_meta, cond_s;       // Two-stage condition sync
    logic       cd_prev, uv_prev;        // Edge history of synced pins
    chsf_acc_t  acc;                     // Access from serial engine
    logic [7:0] rd_data;                 // Read mux result
    logic       rd0, rd1, wr0, wr1, wr2; // Decoded strobes
    logic       cd_toggle, uv_rise;      // Derived events
    logic       sda_oe_eng;              // Engine pin enable

    // Status register state
    logic [1:0] charge_state, next_charge_state;
    logic       reset_flag, next_reset_flag;
    logic       timer_flag, next_timer_flag;
    logic       dpm, next_dpm;
    logic       cd_state, next_cd_state;
    logic       sw_en, next_sw_en;
    // Fault register and temp-sense fault state
    logic       ov_flag, next_ov_flag;
    logic       uv_flag, next_uv_flag;
    logic       lock_flag, next_lock_flag;
    logic       ocp_flag, next_ocp_flag;
    logic [1:0] ts_fault, next_ts_fault;
    chsf_ctrl_t next_ctrl;               // Written controls

    // Serial engine; its enable flop feeds the pin through one more register stage
    chsf_i2c_target u_target (
        .clk_in     (clk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .sda_oe_out (sda_oe_eng),
        .acc_out    (acc),
        .rd_data_in (rd_data)
    );

    // Address decode of the access strobes
    always_comb begin
        rd0 = 1'b0;
        rd1 = 1'b0;
        wr0 = 1'b0;
        wr1 = 1'b0;
        wr2 = 1'b0;
        if (acc.addr == CHSF_OFS_STATUS) begin
            rd0 = acc.rd;
            wr0 = acc.wr;
        end else if (acc.addr == CHSF_OFS_FAULT) begin
            rd1 = acc.rd;
            wr1 = acc.wr;
        end else if (acc.addr == CHSF_OFS_TS) begin
            wr2 = acc.wr;
        end
        cd_toggle = cond_s.chip_disable_pin ^ cd_prev;
        uv_rise   = cond_s.input_undervoltage & ~uv_prev;
    end

    // Read mux; ship bit is write-only and reads zero
    always_comb begin
        rd_data = CHSF_UNMAPPED;
        if (acc.addr == CHSF_OFS_STATUS) begin
            rd_data = 8'h00;
            rd_data[CHSF_STATE_MSB -: 2] = charge_state;
            rd_data[CHSF_RSTF_BIT]  = reset_flag;
            rd_data[CHSF_TIMER_BIT] = timer_flag;
            rd_data[CHSF_DPM_BIT]   = dpm;
            rd_data[CHSF_CD_BIT]    = cd_state;
            rd_data[CHSF_SWEN_BIT]  = sw_en;
        end else if (acc.addr == CHSF_OFS_FAULT) begin
            rd_data = 8'h00;
            rd_data[CHSF_OV_BIT]   = ov_flag;
            rd_data[CHSF_UV_BIT]   = uv_flag;
            rd_data[CHSF_LOCK_BIT] = lock_flag;
            rd_data[CHSF_OCP_BIT]  = ocp_flag;
            rd_data[CHSF_MASK_MSB -: 4] = ctrl_out.fault_mask;
        end else if (acc.addr == CHSF_OFS_TS) begin
            rd_data = 8'h00;  // Reserved bit reads zero
            rd_data[CHSF_TSEN_BIT] = ctrl_out.ts_enable;
            rd_data[CHSF_TSF_MSB -: 2] = ts_fault;
            rd_data[CHSF_TSLOW_MSB -: 4] = ctrl_out.ts_mask;
        end
    end

    // Flag next values; a new event always beats a read clear
    always_comb begin
        next_charge_state = cond_s.charge_state;
        next_dpm      = cond_s.input_dynamic_power_mgmt;
        next_cd_state = cond_s.chip_disable_pin;
        next_sw_en    = cond_s.output_switch_enabled;
        next_ts_fault = cond_s.ts_fault;
        next_reset_flag = cond_s.reset_event
                        | (reset_flag & ~rd0);
        // Reads never clear it, only a chip-disable edge does
        next_timer_flag = cond_s.timer_event
                        | (timer_flag & ~cd_toggle);
        // Condition held high keeps it set through a read
        next_ov_flag   = cond_s.input_overvoltage
                       | (ov_flag & ~rd1);
        // Edge-set so a lasting low input reports only once
        next_uv_flag   = uv_rise | (uv_flag & ~rd1);
        next_lock_flag = cond_s.battery_lockout
                       | (lock_flag & ~rd1);
        next_ocp_flag  = cond_s.battery_overcurrent
                       | (ocp_flag & ~rd1);
    end

    // Writable fields only; read-only bits drop the write data
    always_comb begin
        next_ctrl = ctrl_out;
        if (wr0)
            next_ctrl.ship_request = acc.wdata[CHSF_SHIP_BIT];
        if (wr1)
            next_ctrl.fault_mask = acc.wdata[CHSF_MASK_MSB -: 4];
        if (wr2) begin
            next_ctrl.ts_enable = acc.wdata[CHSF_TSEN_BIT];
            next_ctrl.ts_mask   = acc.wdata[CHSF_TSLOW_MSB -: 4];
        end
    end

    // Registers, all frozen while the enable is low
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cond_meta    <= '0;
            cond_s       <= '0;
            cd_prev      <= 1'b0;
            uv_prev      <= 1'b0;
            charge_state <= 2'h0;
            reset_flag   <= 1'b0;
            timer_flag   <= 1'b0;
            dpm          <= 1'b0;
            cd_state     <= 1'b0;
            sw_en        <= CHSF_SWEN_RST;
            ov_flag      <= 1'b0;
            uv_flag      <= 1'b0;
            lock_flag    <= 1'b0;
            ocp_flag     <= 1'b0;
            ts_fault     <= 2'h0;
            ctrl_out     <= {CHSF_SHIP_RST, CHSF_MASK_RST,
                             CHSF_TSEN_RST, CHSF_TSLOW_RST};
            sda_out      <= 1'b0;
            sda_oe_out   <= 1'b0;
        end else if (ce_in) begin
            cond_meta    <= cond_in;
            cond_s       <= cond_meta;
            cd_prev      <= cond_s.chip_disable_pin;
            uv_prev      <= cond_s.input_undervoltage;
            charge_state <= next_charge_state;
            reset_flag   <= next_reset_flag;
            timer_flag   <= next_timer_flag;
            dpm          <= next_dpm;
            cd_state     <= next_cd_state;
            sw_en        <= next_sw_en;
            ov_flag      <= next_ov_flag;
            uv_flag      <= next_uv_flag;
            lock_flag    <= next_lock_flag;
            ocp_flag     <= next_ocp_flag;
            ts_fault     <= next_ts_fault;
            ctrl_out     <= next_ctrl;
            sda_out      <= 1'b0;  // Open drain: only ever pulls low
            sda_oe_out   <= sda_oe_eng;
        end
    end

    // Checks on the register behaviour
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    state_field_a: assert property (rd0 && $past(ce_in) |->
        rd_data[7:6] == $past(cond_s.charge_state))
        else $error("state field wrong");
    ship_write_a: assert property (ce_in && wr0 |=>
        ctrl_out.ship_request == $past(acc.wdata[5]))
        else $error("ship request not written");
    reset_clear_a: assert property (ce_in && rd0 &&
        !cond_s.reset_event |=> !reset_flag)
        else $error("reset fault not cleared by read");
    timer_hold_a: assert property (ce_in && timer_flag &&
        !cd_toggle |=> timer_flag) else $error("timer fault lost");
    dpm_live_a: assert property (ce_in |=>
        dpm == $past(cond_s.input_dynamic_power_mgmt))
        else $error("power limit bit not live");
    ov_persist_a: assert property (ce_in &&
        cond_s.input_overvoltage |=> ov_flag)
        else $error("overvoltage flag dropped");
    uv_once_a: assert property (ce_in && rd1 && !uv_rise
        |=> !uv_flag ##1 (!uv_flag || $past(uv_rise)))
        else $error("undervoltage flag repeated");
    lock_persist_a: assert property (ce_in &&
        cond_s.battery_lockout |=> lock_flag)
        else $error("lockout flag dropped");
    ocp_clear_a: assert property (ce_in && rd1 &&
        !cond_s.battery_overcurrent |=> !ocp_flag)
        else $error("overcurrent flag not cleared");
    mask_write_a: assert property (ce_in && wr1 |=>
        ctrl_out.fault_mask == $past(acc.wdata[3:0]))
        else $error("fault masks not written");
    reset_value_a: assert property ($rose(resetn_in) |->
        ctrl_out.ts_mask == CHSF_TSLOW_RST && ctrl_out.ts_enable
        && sw_en && !ctrl_out.ship_request)
        else $error("wrong reset values");
    unmapped_read_a: assert property (acc.rd &&
        acc.addr > CHSF_OFS_TS |-> rd_data == CHSF_UNMAPPED)
        else $error("unmapped read not all ones");
    ro_ignore_a: assert property (ce_in && wr0 && !reset_flag
        && !cond_s.reset_event |=> !reset_flag)
        else $error("read-only bit took a write");

    // Main scenarios
    read_clear_c: cover property (rd0 && reset_flag);
    ov_read_c:    cover property (rd1 && ov_flag);
    ship_set_c:   cover property (wr0 && acc.wdata[5]);
    fault_st_c:   cover property (charge_state == CHSF_CHG_FAULT);
endmodule : chsf_regs

// ---- test/chsf_host.sv ----
// Host controller model that drives the two-wire bus of chsf
`timescale 1ns/1ps
module chsf_host (
    // Clock and bus lines
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    import chsf_pkg::*;
    // Idle bus: both lines released to the pull-ups
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end
    // Quarter bit of 8 cycles keeps each clock phase at 16 cycles
    task automatic qb();
        repeat (8) @(posedge clk_in);
    endtask : qb
    // One bit; sending 1 releases the line so the target can answer
    task automatic bit_x(input logic b, output logic r);
        sda_low_out <= !b;
        qb();
        scl_out <= 1'b1;
        qb();
        r = sda_in;
        qb();
        scl_out <= 1'b0;
        qb();
    endtask : bit_x
    // Start, also used as repeated start
    task automatic start();
        sda_low_out <= 1'b0;
        qb();
        scl_out <= 1'b1;
        qb();
        sda_low_out <= 1'b1;
        qb();
        scl_out <= 1'b0;
        qb();
    endtask : start
    // Stop: data rises while clock is high
    task automatic stop();
        sda_low_out <= 1'b1;
        qb();
        scl_out <= 1'b1;
        qb();
        sda_low_out <= 1'b0;
        qb();
        qb();
    endtask : stop
    // Byte msb first, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, output logic [7:0] r,
                        output logic n);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(1'b1, n);
    endtask : xfer
    // Register write, address byte acknowledge returned in n
    task automatic wr(input logic [6:0] dev, input logic [7:0] a,
                      input logic [7:0] d, output logic n);
        logic [7:0] r;
        logic       x;
        start();
        xfer({dev, 1'b0}, r, n);
        xfer(a, r, x);
        xfer(d, r, x);
        stop();
    endtask : wr
    // Register read through pointer write and repeated start
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        logic [7:0] y;
        logic       x;
        start();
        xfer({CHSF_TARGET_ADDR, 1'b0}, y, x);
        xfer(a, y, x);
        start();
        xfer({CHSF_TARGET_ADDR, 1'b1}, y, x);
        xfer(8'hFF, r, x); // Not-acknowledge ends the read
        stop();
    endtask : rd
endmodule : chsf_host

// ---- test/chsf_regs_test.sv ----
// Self-checking testbench of the chsf register bank
`timescale 1ns/1ps
module chsf_regs_test;
    import chsf_pkg::*;
    logic       clk_in, resetn_in, scl, host_low, sda_out, sda_oe, ce;
    wire        sda = !(host_low | sda_oe); // Pulled-up data wire
    chsf_cond_t cond, c;                     // Applied and staged inputs
    chsf_ctrl_t ctrl;
    int         error_cnt, checked;
    chsf_regs dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe),
        .cond_in(cond), .ctrl_out(ctrl));
    chsf_host host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
        .sda_low_out(host_low));
    // Free-running 125 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // Watchdog cuts a hang short
    initial begin
        repeat (100000) @(posedge clk_in);
        error_cnt++;
        tally_and_finish();
    end
    task automatic chk(input string nm, input logic [9:0] e, g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, e);
        logic [7:0] r;
        host.rd(a, r);
        chk("reg", {2'h0, e}, {2'h0, r});
    endtask : rchk
    task automatic wr(input logic [7:0] a, d);
        logic n;
        host.wr(CHSF_TARGET_ADDR, a, d, n);
        chk("ack", 10'h000, {9'h000, n});
    endtask : wr
    // Apply staged conditions, let them pass the synchronisers
    task automatic apply();
        @(posedge clk_in);
        cond <= c;
        repeat (12) @(posedge clk_in);
    endtask : apply
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        logic n;
        c = '0;
        c.output_switch_enabled = 1'b1;
        c.charge_state = 2'h2;
        c.input_dynamic_power_mgmt = 1'b1;
        c.ts_fault = 2'h1;
        cond = c;
        resetn_in = 1'b0;
        ce = 1'b1;
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        chk("ctrl", 10'h018, ctrl);
        chk("pin", 10'h000, {9'h000, sda_out});
        rchk(CHSF_OFS_STATUS, 8'h85);
        rchk(CHSF_OFS_FAULT, 8'h00);
        rchk(CHSF_OFS_TS, 8'hA8);
        rchk(8'h03, 8'hFF);
        rchk(8'h7F, 8'hFF);
        $display("test reset finished");
        wr(CHSF_OFS_FAULT, 8'hFA);
        chk("ctrl", 10'h158, ctrl);
        rchk(CHSF_OFS_FAULT, 8'h0A);
        wr(CHSF_OFS_TS, 8'h35);
        chk("ctrl", 10'h145, ctrl);
        rchk(CHSF_OFS_TS, 8'h25);
        wr(CHSF_OFS_STATUS, 8'hFF);
        chk("ctrl", 10'h345, ctrl);
        rchk(CHSF_OFS_STATUS, 8'h85);
        wr(CHSF_OFS_STATUS, 8'h00);
        chk("ctrl", 10'h145, ctrl);
        // Frozen block must neither answer nor take a write
        ce <= 1'b0;
        host.wr(CHSF_TARGET_ADDR, CHSF_OFS_FAULT, 8'h00, n);
        ce <= 1'b1;
        chk("ack", 10'h001, {9'h000, n});
        chk("ctrl", 10'h145, ctrl);
        host.wr(7'h55, CHSF_OFS_FAULT, 8'h00, n);
        chk("ack", 10'h001, {9'h000, n});
        rchk(CHSF_OFS_FAULT, 8'h0A);
        $display("test write finished");
        c.reset_event = 1'b1;
        apply();
        c.reset_event = 1'b0;
        apply();
        rchk(CHSF_OFS_STATUS, 8'h95);
        rchk(CHSF_OFS_STATUS, 8'h85);
        c.timer_event = 1'b1;
        apply();
        c.timer_event = 1'b0;
        apply();
        rchk(CHSF_OFS_STATUS, 8'h8D);
        rchk(CHSF_OFS_STATUS, 8'h8D);
        c.chip_disable_pin = 1'b1;
        apply();
        rchk(CHSF_OFS_STATUS, 8'h87);
        for (int k = 0; k < 4; k++) begin
            c.charge_state = k[1:0];
            apply();
            rchk(CHSF_OFS_STATUS, {k[1:0], 6'h07});
        end
        $display("test status finished");
        c.input_overvoltage = 1'b1;
        c.input_undervoltage = 1'b1;
        c.battery_lockout = 1'b1;
        c.battery_overcurrent = 1'b1;
        apply();
        rchk(CHSF_OFS_FAULT, 8'hFA);
        c.battery_overcurrent = 1'b0;
        apply();
        rchk(CHSF_OFS_FAULT, 8'hBA);
        rchk(CHSF_OFS_FAULT, 8'hAA);
        c.input_overvoltage = 1'b0;
        c.battery_lockout = 1'b0;
        apply();
        rchk(CHSF_OFS_FAULT, 8'hAA);
        rchk(CHSF_OFS_FAULT, 8'h0A);
        $display("test faults finished");
        tally_and_finish();
    end
endmodule : chsf_regs_test
